/* File: bench/tb_top.sv */
// Self-checking testbench for the transmitter mode controller
`timescale 1ns/1ps
`define CHK(a, b) begin testsRun++; if ((a) !== (b)) begin nMismatch++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
    logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, er, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic supplyEnable, operateLed, driverEnableLed, rfEnable, faultLedRed;
    logic supply_good_indicator, ampEnable, remoteState_n, remoteInterlock_n;
    logic remoteOperate_n, remoteStandby_n, panel_run_select, panel_hold_key;
    logic serialOperate, serialStandby, upLockLost, upAbsent, heatsinkOverTemp;
    logic ampAbsent, output_path_loop_open;
    logic [5:0] req;
    tx_mode_pkg::faults_t flt;
    int nMismatch, testsRun;
    transmitter_mode_controller dut (.*);
    tx_mode_partner partner (.*);
    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    task st(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : st
    task drv(input logic [5:0] r, input logic [4:0] f);
        @(posedge clk);
        req <= r;
        flt <= f;
        st(4);
    endtask : drv
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        // The wait for the slave's answer ends when pready is seen high; the watchdog ends it only if pready never comes
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge clk);
    endtask : apb
    task closeOut;
        $display("comparisons %0d mismatches %0d", testsRun, nMismatch);
        if (nMismatch == 0 && testsRun > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : closeOut
    task t_reset;
        `CHK({supplyEnable, rfEnable, remoteState_n, supply_good_indicator}, 4'h3)
        apb(0, tx_mode_pkg::STATUS_OFFSET, 0);
        `CHK(rd[7:0] & 8'hCD, 8'h40)
        $display("reset test done");
    endtask : t_reset
    task t_remote;
        drv(6'h01, 0);
        `CHK({supplyEnable, operateLed, driverEnableLed}, 3'h7)
        `CHK({rfEnable, remoteState_n}, 2'h2)
        drv(6'h02, 0);
        `CHK({supplyEnable, driverEnableLed, ampEnable}, 3'h0)
        `CHK(supply_good_indicator, 1'b1)
        $display("remote test done");
    endtask : t_remote
    task automatic t_mute;
        logic [4:0] fl [3] = '{5'h10, 5'h08, 5'h01};
        drv(6'h04, 0);
        foreach (fl[i]) begin
            drv(6'h04, fl[i]);
            `CHK({supplyEnable, rfEnable, operateLed}, 3'h5)
            drv(6'h04, 0);
            `CHK(rfEnable, 1'b1)
        end
        drv(6'h20, 0);
        drv(6'h10, 5'h10);
        `CHK(supplyEnable, 1'b0)
        $display("mute test done");
    endtask : t_mute
    task automatic t_refuse;
        logic [4:0] fl [2] = '{5'h04, 5'h02};
        logic [5:0] pr [3] = '{6'h03, 6'h0C, 6'h30};
        foreach (fl[i]) begin
            drv(6'h10, fl[i]);
            `CHK({supplyEnable, faultLedRed, remoteInterlock_n}, 3'h3)
            drv(6'h10, 0);
            `CHK({supplyEnable, faultLedRed}, 2'h2)
        end
        drv(6'h10, 5'h04);
        `CHK(supplyEnable, 1'b0)
        foreach (pr[i]) begin
            drv(pr[i], 0);
            `CHK(supplyEnable, 1'b0)
        end
        drv(0, 0);
        $display("refuse test done");
    endtask : t_refuse
    task t_apb;
        apb(1, tx_mode_pkg::MASK_OFFSET, 1);
        apb(1, tx_mode_pkg::EVENT_OFFSET, 32'h1F);
        apb(1, tx_mode_pkg::CTRL_OFFSET, 1);
        `CHK({irq, supplyEnable}, 2'h3)
        apb(1, tx_mode_pkg::EVENT_OFFSET, 1);
        `CHK(irq, 1'b0)
        apb(0, tx_mode_pkg::MASK_OFFSET, 0);
        `CHK(rd, 32'h1)
        apb(0, 8'h20, 0);
        `CHK({er, rd}, 33'h100000000)
        apb(1, tx_mode_pkg::CTRL_OFFSET, 2);
        `CHK(supplyEnable, 1'b0)
        apb(0, tx_mode_pkg::EVENT_OFFSET, 0);
        `CHK(rd, 32'h00000002)
        apb(0, tx_mode_pkg::INPUTS_OFFSET, 0);
        `CHK(rd, 32'h00000600)
        // Operate asked while the upconverter is unlocked: refused, fault and mute shown
        drv(6'h10, 5'h10);
        apb(0, tx_mode_pkg::STATUS_OFFSET, 0);
        `CHK(rd, 32'h000000F2)
        apb(0, tx_mode_pkg::EVENT_OFFSET, 0);
        `CHK(rd, 32'h00000016)
        drv(0, 0);
        $display("register test done");
    endtask : t_apb
    initial begin
        {psel, penable, pwrite, paddr, pwdata, req, flt} = '0;
        nMismatch = 0;
        testsRun = 0;
        sys_rst = 1;
        repeat (3) @(posedge clk);
        sys_rst <= 0;
        st(4);
        t_reset;
        t_remote;
        t_mute;
        t_refuse;
        t_apb;
        closeOut;
    end
    initial begin
        repeat (20000) @(posedge clk);
        nMismatch++;
        closeOut;
    end
endmodule : tb_top

/* File: bench/tx_mode_partner.sv */
// Far-side model: remote terminal block, panel keys, serial link, fault pins
`timescale 1ns/1ps
module tx_mode_partner (
    input wire logic [5:0] req,
    input wire tx_mode_pkg::faults_t flt,
    output logic remoteOperate_n,
    output logic remoteStandby_n,
    output logic panel_run_select,
    output logic panel_hold_key,
    output logic serialOperate,
    output logic serialStandby,
    output logic upLockLost,
    output logic upAbsent,
    output logic heatsinkOverTemp,
    output logic ampAbsent,
    output logic output_path_loop_open
);
    // Remote lines are pulled to ground to request
    assign remoteOperate_n = ~req[0];
    assign remoteStandby_n = ~req[1];
    assign panel_run_select = req[2];
    assign panel_hold_key = req[3];
    assign serialOperate = req[4];
    assign serialStandby = req[5];
    assign upLockLost = flt.upLockLost;
    assign upAbsent = flt.upAbsent;
    assign heatsinkOverTemp = flt.heatsinkOverTemp;
    assign ampAbsent = flt.ampAbsent;
    assign output_path_loop_open = flt.loopOpen;
endmodule : tx_mode_partner

/* File: bench/tx_mode_props.sv */
// Checker for the transmitter mode controller outputs
`timescale 1ns/1ps
module tx_mode_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic upLockLost,
    input wire logic upAbsent,
    input wire logic heatsinkOverTemp,
    input wire logic ampAbsent,
    input wire logic output_path_loop_open,
    input wire logic supplyEnable,
    input wire logic operateLed,
    input wire logic driverEnableLed,
    input wire logic rfEnable,
    input wire logic faultLedRed,
    input wire logic supply_good_indicator,
    input wire logic ampEnable,
    input wire logic remoteState_n,
    input wire logic remoteInterlock_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_opOut; supplyEnable |-> operateLed && driverEnableLed && ampEnable; endproperty
    a_opOut: assert property (p_opOut) else $error("operate outputs off");
    property p_sbOut; !supplyEnable |-> !operateLed && !ampEnable && supply_good_indicator;
    endproperty
    a_sbOut: assert property (p_sbOut) else $error("standby outputs on");
    property p_rf; rfEnable |-> supplyEnable; endproperty
    a_rf: assert property (p_rf) else $error("rf without operate");
    property p_mute; (upLockLost || upAbsent || output_path_loop_open)[*4] |-> !rfEnable;
    endproperty
    a_mute: assert property (p_mute) else $error("rf not muted");
    property p_heat; (heatsinkOverTemp || ampAbsent)[*4] |-> !supplyEnable; endproperty
    a_heat: assert property (p_heat) else $error("operate while blocked");
    property p_state; remoteState_n == !supplyEnable; endproperty
    a_state: assert property (p_state) else $error("remote state wrong");
    property p_intl; remoteInterlock_n == faultLedRed; endproperty
    a_intl: assert property (p_intl) else $error("interlock output wrong");
    property p_reset; $fell(sys_rst) |-> !supplyEnable && !rfEnable && remoteState_n;
    endproperty
    a_reset: assert property (p_reset) else $error("not standby after reset");
endmodule : tx_mode_props
bind transmitter_mode_controller tx_mode_props u_props (.*);

/* File: pkg/tx_mode_pkg.sv */
// Package for the transmitter mode controller: register map, fields and types
package tx_mode_pkg;
    // Register byte offsets on APB
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] EVENT_OFFSET = 8'h08;
    localparam logic [7:0] MASK_OFFSET = 8'h0C;
    localparam logic [7:0] INPUTS_OFFSET = 8'h10;

    // Control register bits (write one pulses a command)
    localparam int CTRL_OPERATE_BIT = 0;
    localparam int CTRL_STANDBY_BIT = 1;

    // Event bits
    localparam int EV_ENTER_OPERATE = 0;
    localparam int EV_ENTER_STANDBY = 1;
    localparam int EV_FAULT = 2;
    localparam int EV_MUTE = 3;
    localparam int EV_REFUSED = 4;
    localparam int EVENT_WIDTH = 5;

    localparam logic [EVENT_WIDTH-1:0] MASK_RESET = 5'h00;
    localparam logic [31:0] SLVERR_DATA = 32'h0000_0000;

    // Mode states, Gray coded
    typedef enum logic [0:0] {
        MODE_STANDBY = 1'b0,
        MODE_OPERATE = 1'b1
    } mode_t;

    // Fault and interlock inputs, all sampled from pins
    typedef struct packed {
        logic upLockLost;
        logic upAbsent;
        logic heatsinkOverTemp;
        logic ampAbsent;
        logic loopOpen;
    } faults_t;

    // Commands from one source
    typedef struct packed {
        logic operate;
        logic standby;
    } cmd_t;

    // Indicator and drive outputs
    typedef struct packed {
        logic supplyEnable;
        logic operateLed;
        logic driverEnableLed;
        logic rfEnable;
        logic faultLedRed;
        logic supplyGoodIndicator;
        logic ampEnable;
    } drive_t;
endpackage : tx_mode_pkg

/* File: rtl/transmitter_mode_controller.sv */
// Transmitter operate/standby/mute controller with APB registers
`timescale 1ns/1ps
// Function
// - In operate the +28 V supply enable and operate indicator are on.
// - In standby the supply enable and operate indicator are off, supply-good stays lit.
// - The driver amplifier enable indicator follows operate mode.
// - Mute keeps the supply on but blocks RF; RF flows only when operating and unmuted.
// - Upconverter unlock or absence mutes while staying in operate.
// - Operate is requested by a low remote operate line, panel select or serial command.
// - Operate is refused above heatsink temperature limit or while muted by the upconverter.
// - Operate is refused while the amplifier presence interlock is high.
// - Standby is entered by a low remote standby line, panel key or serial command.
// - Operate is refused while any fault is present or remote standby is active.
// - Operation is allowed only with the output path loop closed; an open loop mutes.
// - In standby the output amplifier is disabled.
// - A fault lights the fault indicator red and holds mute or standby until removed.
// - The remote state output is driven low while in operate.
// - The remote interlock output is driven low whenever not faulted.
module transmitter_mode_controller (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic remoteOperate_n,
    input wire logic remoteStandby_n,
    input wire logic panel_run_select,
    input wire logic panel_hold_key,
    input wire logic serialOperate,
    input wire logic serialStandby,
    input wire logic upLockLost,
    input wire logic upAbsent,
    input wire logic heatsinkOverTemp,
    input wire logic ampAbsent,
    input wire logic output_path_loop_open,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic supplyEnable,
    output logic operateLed,
    output logic driverEnableLed,
    output logic rfEnable,
    output logic faultLedRed,
    output logic supply_good_indicator,
    output logic ampEnable,
    output logic remoteState_n,
    output logic remoteInterlock_n,
    output logic irq
);
    // Two-stage synchronisers for all pin inputs
    localparam int NPIN = 11;
    logic [NPIN-1:0] pinRaw;
    logic [NPIN-1:0] pinMeta;
    logic [NPIN-1:0] pinSync;
    assign pinRaw = {remoteOperate_n, remoteStandby_n, panel_run_select, panel_hold_key,
                     serialOperate, serialStandby, upLockLost, upAbsent,
                     heatsinkOverTemp, ampAbsent, output_path_loop_open};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    pinMeta[gi] <= (gi == 10 || gi == 9) ? 1'b1 : 1'b0;
                    pinSync[gi] <= (gi == 10 || gi == 9) ? 1'b1 : 1'b0;
                end else begin
                    pinMeta[gi] <= pinRaw[gi];
                    pinSync[gi] <= pinMeta[gi];
                end
            end
        end
    endgenerate

    tx_mode_pkg::faults_t faults;
    assign faults = '{upLockLost: pinSync[4], upAbsent: pinSync[3],
                      heatsinkOverTemp: pinSync[2], ampAbsent: pinSync[1],
                      loopOpen: pinSync[0]};

    // Bus command pulses
    logic busOperate;
    logic busStandby;

    // Request collection per source
    tx_mode_pkg::cmd_t remoteCmd;
    tx_mode_pkg::cmd_t panelCmd;
    tx_mode_pkg::cmd_t serialCmd;
    assign remoteCmd = '{operate: ~pinSync[10], standby: ~pinSync[9]};
    assign panelCmd = '{operate: pinSync[8], standby: pinSync[7]};
    assign serialCmd = '{operate: pinSync[6] | busOperate, standby: pinSync[5] | busStandby};

    logic reqOperate;
    logic reqStandby;
    assign reqOperate = remoteCmd.operate | panelCmd.operate | serialCmd.operate;
    assign reqStandby = remoteCmd.standby | panelCmd.standby | serialCmd.standby;

    // Condition decode
    logic upMute;
    logic anyFault;
    logic mute;
    logic operateBlocked;
    assign upMute = faults.upLockLost | faults.upAbsent;
    assign anyFault = upMute | faults.heatsinkOverTemp | faults.ampAbsent | faults.loopOpen;
    assign mute = upMute | faults.loopOpen;
    assign operateBlocked = faults.heatsinkOverTemp | upMute
                          | faults.ampAbsent
                          | anyFault | remoteCmd.standby;

    // Mode state machine
    tx_mode_pkg::mode_t mode;
    tx_mode_pkg::mode_t next_mode;
    logic refused;
    always_comb begin
        next_mode = mode;
        refused = 1'b0;
        case (mode)
            tx_mode_pkg::MODE_STANDBY: begin
                if (reqStandby) begin
                    next_mode = tx_mode_pkg::MODE_STANDBY;
                end else if (reqOperate) begin
                    if (operateBlocked) begin
                        refused = 1'b1;
                    end else begin
                        next_mode = tx_mode_pkg::MODE_OPERATE;
                    end
                end
            end
            tx_mode_pkg::MODE_OPERATE: begin
                // A heat or amplifier fault drops to standby; upconverter and loop only mute
                if (reqStandby || faults.heatsinkOverTemp || faults.ampAbsent) begin
                    next_mode = tx_mode_pkg::MODE_STANDBY;
                end
            end
            default: next_mode = tx_mode_pkg::MODE_STANDBY;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode <= tx_mode_pkg::MODE_STANDBY;
        end else begin
            mode <= next_mode;
        end
    end

    // Output drives, registered
    logic inOperate;
    assign inOperate = (next_mode == tx_mode_pkg::MODE_OPERATE);
    tx_mode_pkg::drive_t drive;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            drive <= '{supplyEnable: 1'b0, operateLed: 1'b0, driverEnableLed: 1'b0,
                       rfEnable: 1'b0, faultLedRed: 1'b0, supplyGoodIndicator: 1'b1,
                       ampEnable: 1'b0};
            remoteState_n <= 1'b1;
            remoteInterlock_n <= 1'b0;
        end else begin
            drive.supplyEnable <= inOperate;
            drive.operateLed <= inOperate;
            drive.driverEnableLed <= inOperate;
            drive.rfEnable <= inOperate & ~mute;
            drive.faultLedRed <= anyFault;
            drive.supplyGoodIndicator <= 1'b1;
            drive.ampEnable <= inOperate;
            remoteState_n <= ~inOperate;
            remoteInterlock_n <= anyFault;
        end
    end
    assign supplyEnable = drive.supplyEnable;
    assign operateLed = drive.operateLed;
    assign driverEnableLed = drive.driverEnableLed;
    assign rfEnable = drive.rfEnable;
    assign faultLedRed = drive.faultLedRed;
    assign supply_good_indicator = drive.supplyGoodIndicator;
    assign ampEnable = drive.ampEnable;

    // Event sources
    logic [tx_mode_pkg::EVENT_WIDTH-1:0] evSet;
    logic faultPrev;
    logic mutePrev;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            faultPrev <= 1'b0;
            mutePrev <= 1'b0;
        end else begin
            faultPrev <= anyFault;
            mutePrev <= mute & (mode == tx_mode_pkg::MODE_OPERATE);
        end
    end
    always_comb begin
        evSet = '0;
        evSet[tx_mode_pkg::EV_ENTER_OPERATE] = (mode == tx_mode_pkg::MODE_STANDBY) & inOperate;
        evSet[tx_mode_pkg::EV_ENTER_STANDBY] = (mode == tx_mode_pkg::MODE_OPERATE) & ~inOperate;
        evSet[tx_mode_pkg::EV_FAULT] = anyFault & ~faultPrev;
        evSet[tx_mode_pkg::EV_MUTE] = mute & (mode == tx_mode_pkg::MODE_OPERATE) & ~mutePrev;
        evSet[tx_mode_pkg::EV_REFUSED] = refused;
    end

    // APB slave, zero wait states
    function automatic logic isAddr(input logic [7:0] a, input logic [7:0] off);
        isAddr = (a == off);
    endfunction : isAddr

    logic wrEn;
    logic rdAccess;
    assign wrEn = psel & penable & pwrite;
    assign rdAccess = psel & penable & ~pwrite;
    assign pready = 1'b1;

    logic mapped;
    assign mapped = isAddr(paddr, tx_mode_pkg::CTRL_OFFSET)
                  | isAddr(paddr, tx_mode_pkg::STATUS_OFFSET)
                  | isAddr(paddr, tx_mode_pkg::EVENT_OFFSET)
                  | isAddr(paddr, tx_mode_pkg::MASK_OFFSET)
                  | isAddr(paddr, tx_mode_pkg::INPUTS_OFFSET);
    assign pslverr = psel & penable & ~mapped;

    assign busOperate = wrEn & isAddr(paddr, tx_mode_pkg::CTRL_OFFSET)
                      & pwdata[tx_mode_pkg::CTRL_OPERATE_BIT];
    assign busStandby = wrEn & isAddr(paddr, tx_mode_pkg::CTRL_OFFSET)
                      & pwdata[tx_mode_pkg::CTRL_STANDBY_BIT];

    logic [tx_mode_pkg::EVENT_WIDTH-1:0] events;
    logic [tx_mode_pkg::EVENT_WIDTH-1:0] mask;
    logic [tx_mode_pkg::EVENT_WIDTH-1:0] evClear;
    assign evClear = (wrEn & isAddr(paddr, tx_mode_pkg::EVENT_OFFSET))
                   ? pwdata[tx_mode_pkg::EVENT_WIDTH-1:0] : '0;

    // Set wins over a simultaneous clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            events <= '0;
        end else begin
            events <= (events & ~evClear) | evSet;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mask <= tx_mode_pkg::MASK_RESET;
        end else if (wrEn && isAddr(paddr, tx_mode_pkg::MASK_OFFSET)) begin
            mask <= pwdata[tx_mode_pkg::EVENT_WIDTH-1:0];
        end
    end

    assign irq = |(events & mask);

    always_comb begin
        prdata = tx_mode_pkg::SLVERR_DATA;
        if (rdAccess) begin
            if (isAddr(paddr, tx_mode_pkg::STATUS_OFFSET)) begin
                prdata = {24'h000000, remoteInterlock_n, remoteState_n, drive.faultLedRed,
                          mute, drive.rfEnable, drive.supplyEnable, operateBlocked,
                          (mode == tx_mode_pkg::MODE_OPERATE)};
            end else if (isAddr(paddr, tx_mode_pkg::EVENT_OFFSET)) begin
                prdata = {27'h0000000, events};
            end else if (isAddr(paddr, tx_mode_pkg::MASK_OFFSET)) begin
                prdata = {27'h0000000, mask};
            end else if (isAddr(paddr, tx_mode_pkg::INPUTS_OFFSET)) begin
                prdata = {21'h000000, pinSync};
            end
        end
    end
endmodule : transmitter_mode_controller
